// ### common/pspc_pkg.sv
// shared constants and types for the power stage protection link
package pspc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // clock and timing
   localparam int unsigned CLK_HZ        = 40_000_000;
   localparam int unsigned CLK_PER_US    = CLK_HZ / 1_000_000;
   localparam int unsigned BST_CHARGE_US = 800;   // bootstrap charge time
   localparam int unsigned PWRUP_US      = 1000;  // reset held low after power
   localparam int unsigned PWRUP_CYCLES  = PWRUP_US * CLK_PER_US;
   localparam int unsigned RST_PULSE_NS  = 1000;  // recovery reset pulse
   localparam int unsigned RST_PULSE_CYC = (RST_PULSE_NS * CLK_PER_US
                                            + 999) / 1000;
   localparam int unsigned PWM_MIN_KHZ   = 350;
   localparam int unsigned PWM_MAX_KHZ   = 400;
   // period limits in clocks: least rounds up, longest rounds down
   localparam logic [7:0]  PER_MIN = 8'((CLK_HZ + PWM_MAX_KHZ * 1000 - 1)
                                        / (PWM_MAX_KHZ * 1000));
   localparam logic [7:0]  PER_MAX = 8'(CLK_HZ / (PWM_MIN_KHZ * 1000));
   // self recovery span in pwm cycles
   localparam logic [9:0]  AR_CYCLES = 10'h200;
   localparam logic [9:0]  AR_HALF   = AR_CYCLES >> 1;

   ////////////////////////////////////////////////////////////////////////
   // controller register map
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_PERIOD = 8'h08;
   localparam logic [7:0] ADDR_DUTY   = 8'h0c;
   localparam int CTRL_RUN_BIT     = 0;
   localparam int CTRL_PWM_BIT     = 1;
   localparam int CTRL_RECOVER_BIT = 2;
   localparam int STAT_RESET_BIT   = 0;
   localparam int STAT_WARM_BIT    = 1;
   localparam int STAT_READY_BIT   = 2;
   localparam int STAT_COND_LSB    = 4;
   localparam int STAT_PEND_BIT    = 6;
   localparam logic [7:0] PERIOD_RST = 8'h68;  // 104 clocks, 384.6 kHz
   localparam logic [7:0] DUTY_RST   = 8'h34;

   ////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [1:0] {
      PM_AUTO,
      PM_LATCH,
      PM_UNPROT
   } pspc_mode_t;

   // status pair decode: {heat_warning_n, fault_flag_n}
   typedef enum logic [1:0] {
      COND_OVERHEAT = 2'b00,
      COND_WARNING  = 2'b01,
      COND_OC_UV    = 2'b10,
      COND_NORMAL   = 2'b11
   } pspc_cond_t;

endpackage : pspc_pkg

// ### common/pspc_link_if.sv
// link between the pwm controller and the power stage
`timescale 1ns/1ps
interface pspc_link_if;
   logic [1:0] pwm_drive_input;
   logic       reset_n;
   logic       fault_flag_n_o;
   logic       fault_flag_n_oe;
   logic       heat_warning_n_o;
   logic       heat_warning_n_oe;
   logic       fault_flag_n;
   logic       heat_warning_n;

   // open-drain wires with internal pullup
   assign fault_flag_n   = fault_flag_n_oe ? fault_flag_n_o : 1'b1;
   assign heat_warning_n = heat_warning_n_oe ? heat_warning_n_o : 1'b1;

   modport device (
      input  pwm_drive_input,
      input  reset_n,
      output fault_flag_n_o,
      output fault_flag_n_oe,
      output heat_warning_n_o,
      output heat_warning_n_oe
   );

   modport host (
      output pwm_drive_input,
      output reset_n,
      input  fault_flag_n,
      input  heat_warning_n
   );
endinterface : pspc_link_if

// ### logic/pspc_sync.sv
// two flip-flop synchroniser, one per bit
`timescale 1ns/1ps
module pspc_sync #(
   parameter int W = 1
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;

   // first stage feeds only the second
   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            meta[i] <= 1'b0;
            q[i]    <= 1'b0;
         end else begin
            meta[i] <= d[i];
            q[i]    <= meta[i];
         end
      end
   end
endmodule : pspc_sync

// ### logic/pspc_stage.sv
// power stage protection logic: mute, fault latch, self recovery
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps

// Contract
// - reset low turns every transistor off
// - controller holds reset low about 1 ms
// - release reset only with 350-400 kHz pwm
// - never hold pwm constantly high
// - modulator initialised before reset goes high
// - power down: reset low before pwm stops
// - fault flag released in reset, low in protection
// - warning low above 125 C
// - status pair decodes four conditions
// - any error forces Hi-Z
// - recover: errors cleared, then pulse reset
// - overcurrent monitored per transistor
// - shared undervoltage lockout
// - reset low mutes switching
// - reset fall clears latch, high resumes
// - recovery counts pwm cycles, one counter
// - latch clears at n/2, resume at n=512
// - latch mode holds Hi-Z until reset toggle
// - test mode disables all protection
// - straps select protection mode
// - output strap low selects bridge-tied
module pspc_stage
   import pspc_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   pspc_link_if.device     link,
   input  wire logic       protect_sel_high,
   input  wire logic       protect_sel_low,
   input  wire logic       output_cfg_strap,
   input  wire logic [3:0] oc_trip,
   input  wire logic       heat_warn_cmp,
   input  wire logic       heat_err_cmp,
   input  wire logic       gate_supply_low,
   output logic      [1:0] hs_gate_on,
   output logic      [1:0] ls_gate_on,
   output logic            stage_hiz,
   output logic            overcurrent_fault,
   output logic            overheat_error
);

   typedef enum logic [1:0] {
      ST_MUTE,
      ST_RUN,
      ST_HOLD,
      ST_RECOVER
   } pspc_state_t;

   localparam int SYNC_W = 13;

   logic [SYNC_W-1:0] raw;
   logic [SYNC_W-1:0] sy;
   logic [1:0]        pwm_s;
   logic              rst_s;
   logic [3:0]        oc_s;
   logic              warn_s;
   logic              ote_s;
   logic              uv_s;
   logic              selh_s;
   logic              sell_s;
   logic              cfg_s;
   logic              rst_d;
   logic              pwm_d;
   logic              rst_fall;
   logic              pwm_rise;
   pspc_mode_t        mode;
   pspc_mode_t        next_mode;
   logic              cfg_btl;
   logic              prot_on;
   logic              err_evt;
   logic              prot_latch;
   logic              half_done;
   logic              full_done;
   logic [9:0]        cnt;
   pspc_state_t       state;
   pspc_state_t       next_state;
   logic              switching;
   logic              drv_low;

   ////////////////////////////////////////////////////////////////////////
   // synchronise pins, straps and comparators
   assign raw = {link.pwm_drive_input, link.reset_n, oc_trip, heat_warn_cmp,
                 heat_err_cmp, gate_supply_low, protect_sel_high,
                 protect_sel_low, output_cfg_strap};

   pspc_sync #(.W(SYNC_W)) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (raw),
      .q       (sy)
   );

   assign {pwm_s, rst_s, oc_s, warn_s, ote_s, uv_s, selh_s, sell_s,
           cfg_s} = sy;

   // edge detection on synchronised reset and pwm a
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_d <= 1'b0;
         pwm_d <= 1'b0;
      end else begin
         rst_d <= rst_s;
         pwm_d <= pwm_s[0];
      end
   end

   assign rst_fall = rst_d & ~rst_s;
   assign pwm_rise = pwm_s[0] & ~pwm_d;

   ////////////////////////////////////////////////////////////////////////
   // strap decode
   always_comb begin
      case ({selh_s, sell_s})
         2'b00:   next_mode = PM_AUTO;
         2'b01:   next_mode = PM_LATCH;
         2'b10:   next_mode = PM_UNPROT;
         default: next_mode = PM_LATCH;
      endcase
   end

   // straps caught while reset is low, held while it is high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode    <= PM_LATCH;
         cfg_btl <= 1'b0;
      end else if (!rst_s) begin
         mode    <= next_mode;
         cfg_btl <= ~cfg_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // error detection
   assign prot_on = (mode != PM_UNPROT);
   // any transistor trip, heat error or gate undervoltage
   assign err_evt = prot_on & ((|oc_s) | ote_s | uv_s);

   assign half_done = (mode == PM_AUTO) && (state == ST_HOLD) && pwm_rise
                      && (cnt == AR_HALF - 10'h001);
   assign full_done = (state == ST_RECOVER) && pwm_rise
                      && (cnt == AR_CYCLES - 10'h001);

   // protection latch, a new error wins over any clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prot_latch <= 1'b0;
      end else if (err_evt) begin
         prot_latch <= 1'b1;
      end else if (rst_fall) begin
         prot_latch <= 1'b0;
      end else if (half_done) begin
         prot_latch <= 1'b0;
      end
   end

   // single recovery counter for both bridges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 10'h000;
      end else if (err_evt || (state != ST_HOLD && state != ST_RECOVER)) begin
         cnt <= 10'h000;
      end else if (pwm_rise) begin
         cnt <= cnt + 10'h001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // stage sequencing
   always_comb begin
      next_state = state;
      case (state)
         ST_MUTE: begin
            if (rst_s && (prot_latch || err_evt)) begin
               next_state = ST_HOLD;
            end else if (rst_s && cfg_btl) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (err_evt) begin
               next_state = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (half_done) begin
               next_state = ST_RECOVER;
            end
         end
         ST_RECOVER: begin
            if (err_evt) begin
               next_state = ST_HOLD;
            end else if (full_done) begin
               next_state = ST_RUN;
            end
         end
         default: next_state = ST_MUTE;
      endcase
      if (!rst_s) begin
         next_state = ST_MUTE;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_MUTE;
      end else begin
         state <= next_state;
      end
   end

   assign switching = (state == ST_RUN) && rst_s && cfg_btl;

   ////////////////////////////////////////////////////////////////////////
   // gate drive, off unless switching
   for (genvar i = 0; i < 2; i++) begin : g_bridge
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            hs_gate_on[i] <= 1'b0;
            ls_gate_on[i] <= 1'b0;
         end else begin
            hs_gate_on[i] <= switching & pwm_s[i];
            ls_gate_on[i] <= switching & ~pwm_s[i];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage_hiz <= 1'b1;
      end else begin
         stage_hiz <= ~switching;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // open-drain status pins, low level only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drv_low                <= 1'b0;
         link.fault_flag_n_oe   <= 1'b0;
         link.heat_warning_n_oe <= 1'b0;
      end else begin
         drv_low                <= 1'b0;
         link.fault_flag_n_oe   <= rst_s & prot_latch;
         // heat error also pulls warning so the pair reads overheat
         link.heat_warning_n_oe <= warn_s | ote_s;
      end
   end

   assign link.fault_flag_n_o   = drv_low;
   assign link.heat_warning_n_o = drv_low;

   // raw fault indications for local use
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overcurrent_fault <= 1'b0;
         overheat_error    <= 1'b0;
      end else begin
         overcurrent_fault <= |oc_s;
         overheat_error    <= ote_s;
      end
   end

endmodule : pspc_stage

// ### logic/pspc_ctrl.sv
// pwm controller end: pwm generator, reset sequencing, apb registers
`timescale 1ns/1ps
module pspc_ctrl
   import pspc_pkg::*;
#(
   parameter int unsigned RELEASE_WAIT = PWRUP_CYCLES
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   pspc_link_if.host        link
);

   typedef enum logic [1:0] {
      H_LOW,
      H_HIGH,
      H_PULSE
   } pspc_hstate_t;

   logic [1:0]   pin_s;
   logic         run_req;
   logic         pwm_en;
   logic         rec_pend;
   logic [7:0]   period;
   logic [7:0]   duty;
   logic [7:0]   duty_eff;
   logic [7:0]   phase;
   logic         pwm_run;
   logic         warm;
   logic [15:0]  pu_cnt;
   logic         pu_done;
   logic         period_ok;
   logic [5:0]   pulse_cnt;
   logic         rst_out;
   pspc_hstate_t hstate;
   pspc_hstate_t next_hstate;
   logic         acc;
   logic         wr;
   logic         hit;
   logic [31:0]  rdata;
   pspc_cond_t   cond;

   ////////////////////////////////////////////////////////////////////////
   // apb slave, one wait state
   assign acc = psel & penable;
   assign wr  = acc & pready & pwrite;

   always_comb begin
      hit   = 1'b1;
      rdata = 32'h0000_0000;
      case (paddr)
         ADDR_CTRL: begin
            rdata[CTRL_RUN_BIT] = run_req;
            rdata[CTRL_PWM_BIT] = pwm_en;
         end
         ADDR_STATUS: begin
            rdata[STAT_RESET_BIT]                  = rst_out;
            rdata[STAT_WARM_BIT]                   = warm;
            rdata[STAT_READY_BIT]                  = pu_done;
            rdata[STAT_COND_LSB +: 2]              = cond;
            rdata[STAT_PEND_BIT]                   = rec_pend;
         end
         ADDR_PERIOD: rdata[7:0] = period;
         ADDR_DUTY:   rdata[7:0] = duty;
         default:     hit = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= acc & ~pready;
         prdata  <= (acc & ~pready & ~pwrite) ? rdata : 32'h0000_0000;
         pslverr <= acc & ~pready & ~hit;
      end
   end

   // writable registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_req <= 1'b0;
         pwm_en  <= 1'b0;
         period  <= PERIOD_RST;
         duty    <= DUTY_RST;
      end else if (wr) begin
         if (paddr == ADDR_CTRL) begin
            run_req <= pwdata[CTRL_RUN_BIT];
            pwm_en  <= pwdata[CTRL_PWM_BIT];
         end
         if (paddr == ADDR_PERIOD) begin
            period <= pwdata[7:0];
         end
         if (paddr == ADDR_DUTY) begin
            duty <= pwdata[7:0];
         end
      end
   end

   // recovery request, a new request wins over the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rec_pend <= 1'b0;
      end else if (wr && paddr == ADDR_CTRL && pwdata[CTRL_RECOVER_BIT]) begin
         rec_pend <= 1'b1;
      end else if (next_hstate == H_PULSE) begin
         rec_pend <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // status pins and decode
   pspc_sync #(.W(2)) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       ({link.heat_warning_n, link.fault_flag_n}),
      .q       (pin_s)
   );

   assign cond = pspc_cond_t'(pin_s);

   ////////////////////////////////////////////////////////////////////////
   // power-up wait before reset may rise
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pu_cnt  <= 16'h0000;
         pu_done <= 1'b0;
      end else if (pu_cnt == 16'(RELEASE_WAIT)) begin
         pu_done <= 1'b1;
      end else begin
         pu_cnt  <= pu_cnt + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pwm generator
   assign period_ok = (period >= PER_MIN) && (period <= PER_MAX);

   // duty kept inside the period so neither phase stays high
   always_comb begin
      duty_eff = duty;
      if (duty >= period) begin
         duty_eff = period - 8'h01;
      end
      if (duty == 8'h00) begin
         duty_eff = 8'h01;
      end
   end

   // pwm stops only once reset is already low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwm_run <= 1'b0;
      end else if (pwm_en && period_ok) begin
         pwm_run <= 1'b1;
      end else if (!rst_out) begin
         pwm_run <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase <= 8'h00;
         warm  <= 1'b0;
      end else if (!pwm_run) begin
         phase <= 8'h00;
         warm  <= 1'b0;
      end else if (phase >= period - 8'h01) begin
         phase <= 8'h00;
         warm  <= 1'b1;
      end else begin
         phase <= phase + 8'h01;
      end
   end

   // complementary drive for the bridge-tied pair
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link.pwm_drive_input <= 2'b00;
      end else begin
         link.pwm_drive_input[0] <= pwm_run & (phase < duty_eff);
         link.pwm_drive_input[1] <= pwm_run & ~(phase < duty_eff);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // reset sequencing
   always_comb begin
      next_hstate = hstate;
      case (hstate)
         H_LOW: begin
            if (run_req && pwm_en && period_ok && warm && pu_done) begin
               next_hstate = H_HIGH;
            end
         end
         H_HIGH: begin
            if (!run_req || !pwm_en || !period_ok) begin
               next_hstate = H_LOW;
            end else if (rec_pend && pin_s[1]) begin
               next_hstate = H_PULSE;
            end
         end
         H_PULSE: begin
            if (pulse_cnt == 6'(RST_PULSE_CYC - 1)) begin
               next_hstate = H_LOW;
            end
         end
         default: next_hstate = H_LOW;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hstate    <= H_LOW;
         pulse_cnt <= 6'h00;
         rst_out   <= 1'b0;
      end else begin
         hstate    <= next_hstate;
         pulse_cnt <= (hstate == H_PULSE) ? pulse_cnt + 6'h01 : 6'h00;
         rst_out   <= (next_hstate == H_HIGH);
      end
   end

   assign link.reset_n = rst_out;

endmodule : pspc_ctrl

// ### bench/pspc_checker.sv
// assertions on the controller to stage link
`timescale 1ns/1ps
module pspc_checker
   import pspc_pkg::*;
#(
   parameter int unsigned RELEASE_WAIT = PWRUP_CYCLES
) (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic [1:0] pwm_drive_input,
   input wire logic       reset_n,
   input wire logic       fault_flag_n,
   input wire logic       heat_warning_n,
   input wire logic       stage_hiz,
   input wire logic [1:0] hs_gate_on,
   input wire logic [1:0] ls_gate_on
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [7:0]  still;
   logic [31:0] up;
   logic        prev;
   // pwm idle span and time since reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         still <= 8'h00;
         up    <= 32'h0;
         prev  <= 1'b0;
      end else begin
         prev  <= pwm_drive_input[0];
         still <= (pwm_drive_input[0] != prev) ? 8'h00
                  : still + (still != 8'hff);
         up    <= up + (up != 32'hffffffff);
      end
   end
   ////////////////////////////////////////////////////////////////////////
   property p_gates_off;
      stage_hiz |-> hs_gate_on == 2'b00 && ls_gate_on == 2'b00;
   endproperty
   a_gates_off: assert property (p_gates_off)
      else $error("gate on in hi-z");
   property p_rel_wait;
      $rose(reset_n) |-> up >= RELEASE_WAIT;
   endproperty
   a_rel_wait: assert property (p_rel_wait)
      else $error("early release");
   property p_rel_pwm;
      $rose(reset_n) |-> still < PER_MAX;
   endproperty
   a_rel_pwm: assert property (p_rel_pwm)
      else $error("release, pwm idle");
   property p_pwm_alive;
      reset_n |-> still <= PER_MAX;
   endproperty
   a_pwm_alive: assert property (p_pwm_alive)
      else $error("pwm stuck");
   property p_flag_rst;
      !reset_n [*4] |=> fault_flag_n;
   endproperty
   a_flag_rst: assert property (p_flag_rst)
      else $error("flag low in reset");
   property p_mute;
      !reset_n [*4] |=> stage_hiz;
   endproperty
   a_mute: assert property (p_mute)
      else $error("switching in mute");
   property p_fault_hiz;
      !fault_flag_n |-> stage_hiz;
   endproperty
   a_fault_hiz: assert property (p_fault_hiz)
      else $error("fault not hi-z");
   property p_recover;
      $fell(reset_n) |-> !reset_n [*8];
   endproperty
   a_recover: assert property (p_recover)
      else $error("short reset");
   c_fault: cover property ($fell(fault_flag_n));
   c_run: cover property ($rose(reset_n));
   c_hot: cover property (!heat_warning_n && !fault_flag_n);
endmodule : pspc_checker

// ### bench/power_stage_protection_control_bench.sv
// self-checking bench for the power stage protection link
`timescale 1ns/1ps
module power_stage_protection_control_bench;
   import pspc_pkg::*;
   typedef struct {logic [32:0] v; logic [32:0] m;} pspc_note_t;
   logic        pclk, presetn, psel, penable, pwrite, look;
   logic        pready, pslverr, sel_h, sel_l, cfg, warn, herr, uv, hiz;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, d;
   logic [3:0]  oc;
   logic [1:0]  hs, ls;
   logic        ocf, ohe;
   int          err_total, n_compared;
   pspc_note_t  notes[$];
   pspc_link_if link ();
   pspc_stage u_pspc_stage (.pclk, .presetn, .link(link),
      .protect_sel_high(sel_h), .protect_sel_low(sel_l),
      .output_cfg_strap(cfg), .oc_trip(oc), .heat_warn_cmp(warn),
      .heat_err_cmp(herr), .gate_supply_low(uv), .hs_gate_on(hs),
      .ls_gate_on(ls), .stage_hiz(hiz), .overcurrent_fault(ocf),
      .overheat_error(ohe));
   pspc_ctrl #(.RELEASE_WAIT(200)) u_pspc_ctrl (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .link(link));
   pspc_checker #(.RELEASE_WAIT(200)) u_pspc_checker (.pclk, .presetn,
      .pwm_drive_input(link.pwm_drive_input), .reset_n(link.reset_n),
      .fault_flag_n(link.fault_flag_n), .stage_hiz(hiz),
      .heat_warning_n(link.heat_warning_n), .hs_gate_on(hs),
      .ls_gate_on(ls));
   // 40 MHz clock
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask : wt
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] x);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= x;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [32:0] v, m);
      notes.push_back('{v, m});
      apb(1'b0, a, 32'h0);
   endtask : rd
   // note {oc, heat err, hiz, fault, warning} for the watcher
   task automatic lk(input logic [2:0] v, input logic [1:0] f = 2'b00);
      notes.push_back('{{28'h0, f, v}, 33'h1f});
      look <= 1'b1;
      @(posedge pclk);
      look <= 1'b0;
      @(posedge pclk);
   endtask : lk
   task automatic setm(input logic [2:0] s);
      apb(1'b1, ADDR_CTRL, 32'h0);
      wt(8);
      lk(3'b111);
      {sel_h, sel_l, cfg} <= s;
      wt(8);
      apb(1'b1, ADDR_CTRL, 32'h3);
      while (link.reset_n !== 1'b1) @(posedge pclk);
      wt(8);
   endtask : setm
   task automatic trip(input logic [6:0] e, input logic [2:0] on, off);
      {uv, herr, warn, oc} <= e;
      wt(8);
      lk(on, {|e[3:0], e[5]});
      rd(ADDR_STATUS, {27'h0, on[0], on[1], 4'h0}, 33'h30);
      {uv, herr, warn, oc} <= 7'h0;
      wt(40);
      lk(off);
   endtask : trip
   task automatic eg(input int n);
      repeat (n) @(posedge link.pwm_drive_input[0]);
      @(posedge pclk);
   endtask : eg
   task automatic cmp(input logic [32:0] got);
      pspc_note_t n;
      n_compared++;
      if (notes.size() == 0) begin
         n.v = '1;
         n.m = 33'h0;
      end else begin
         n = notes.pop_front();
      end
      if ((got & n.m) !== n.v) begin
         err_total++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, n.v);
      end
   endtask : cmp
   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : test_done
   ////////////////////////////////////////////////////////////////////////
   // watcher: oldest note against each result
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite)
         cmp({pslverr, prdata});
      else if (look)
         cmp({28'h0, ocf, ohe, hiz, link.fault_flag_n,
              link.heat_warning_n});
   end
   // hang guard
   initial begin
      wt(90000);
      err_total++;
      test_done();
   end
   // main sequence
   initial begin
      {presetn, psel, penable, pwrite, look, sel_h, sel_l, cfg} = 8'h0;
      {uv, herr, warn, oc} = 7'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      err_total = 0;
      n_compared = 0;
      void'($urandom(86));
      wt(3);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(ADDR_PERIOD, {25'h0, PERIOD_RST}, '1);
      rd(ADDR_DUTY, {25'h0, DUTY_RST}, '1);
      rd(ADDR_STATUS, 33'h30, 33'h31);
      rd(8'h10, 33'h100000000, '1);
      lk(3'b111);
      repeat (4) begin
         d = 32'd1 + ($urandom % 32'd103);
         apb(1'b1, ADDR_DUTY, d);
         rd(ADDR_DUTY, {1'b0, d}, '1);
      end
      setm(3'b010);
      lk(3'b011);
      for (int i = 0; i < 7; i++) begin
         trip(7'h1 << i, (i == 4) ? 3'b010 : (i == 5) ? 3'b100 : 3'b101,
              (i == 4) ? 3'b011 : 3'b101);
         apb(1'b1, ADDR_CTRL, 32'h7);
         while (link.reset_n !== 1'b0) @(posedge pclk);
         while (link.reset_n !== 1'b1) @(posedge pclk);
         wt(8);
         lk(3'b011);
      end
      setm(3'b100);
      trip(7'h1, 3'b011, 3'b011);
      setm(3'b110);
      trip(7'h2, 3'b101, 3'b101);
      setm(3'b011);
      lk(3'b111);
      apb(1'b1, ADDR_PERIOD, 32'h64);
      setm(3'b000);
      oc <= 4'h8;
      wt(8);
      lk(3'b101, 2'b10);
      oc <= 4'h0;
      eg(250);
      lk(3'b101);
      eg(12);
      lk(3'b111);
      eg(244);
      lk(3'b111);
      eg(12);
      lk(3'b011);
      test_done();
   end
endmodule : power_stage_protection_control_bench
